// File: sbra_pkg.sv
// Constants for the subbank register access block
package sbra_pkg;
    localparam int          SBRA_AW         = 7;
    localparam int          SBRA_DW         = 16;
    // ------------------------------------------------------------
    // Direct addresses
    // ------------------------------------------------------------
    localparam logic [6:0]  ADDR_SER2_PTR   = 7'h34;
    localparam logic [6:0]  ADDR_SER2_WIN   = 7'h35;
    localparam logic [6:0]  ADDR_SER0_PTR   = 7'h38;
    localparam logic [6:0]  ADDR_SER0_WIN   = 7'h39;
    localparam logic [6:0]  ADDR_SER1_PTR   = 7'h48;
    localparam logic [6:0]  ADDR_SER1_WIN   = 7'h49;
    localparam logic [6:0]  ADDR_DMA_PRIO   = 7'h54;
    localparam logic [6:0]  ADDR_DMA_PTR    = 7'h55;
    localparam logic [6:0]  ADDR_DMA_WINI   = 7'h56;
    localparam logic [6:0]  ADDR_DMA_WINN   = 7'h57;
    // ------------------------------------------------------------
    // Subbank sizes and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SER_LAST_SUB    = 16'h000E;
    localparam int          SER_NREG        = 15;
    localparam logic [15:0] DMA_LAST_SUB    = 16'h0027;
    localparam int          DMA_NREG        = 40;
    localparam logic [15:0] RST_VAL         = 16'h0000;
endpackage : sbra_pkg

// File: sbra_bank.sv
// Subbank register access: direct pointers and data windows
`timescale 1ns/1ns
`default_nettype none
module sbra_bank
    import sbra_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Data-memory access from the core
    input  wire logic               mem_rd,
    input  wire logic               mem_wr,
    input  wire logic [SBRA_AW-1:0] mem_addr,
    input  wire logic [SBRA_DW-1:0] mem_wdata,
    output logic      [SBRA_DW-1:0] mem_rdata,
    output logic                    mem_hit
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Only the pointers and the priority word have a direct address
    logic [15:0] serial_subbank_pointer [3];
    logic [15:0] ser_ctl                [3][SER_NREG];
    logic [15:0] dma_priority_enable;
    logic [15:0] dma_subbank_pointer;
    logic [15:0] dma_ctl                [DMA_NREG];

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic ser_ok(input logic [15:0] p);
        return p <= SER_LAST_SUB;
    endfunction

    function automatic logic dma_in_range(input logic [15:0] p);
        return p <= DMA_LAST_SUB;
    endfunction

    // Low bits only; callers gate with the range checks above
    function automatic logic [3:0] ser_idx(input logic [15:0] p);
        return p[3:0];
    endfunction

    function automatic logic [5:0] dma_idx(input logic [15:0] p);
        return p[5:0];
    endfunction

    function automatic logic [15:0] pick(input logic sel, input logic [15:0] v);
        return sel ? v : 16'h0000;
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic       acc = mem_rd | mem_wr;
    wire logic [2:0] hit_ptr;
    wire logic [2:0] hit_win;
    assign hit_ptr[0] = mem_addr == ADDR_SER0_PTR;
    assign hit_win[0] = mem_addr == ADDR_SER0_WIN;
    assign hit_ptr[1] = mem_addr == ADDR_SER1_PTR;
    assign hit_win[1] = mem_addr == ADDR_SER1_WIN;
    assign hit_ptr[2] = mem_addr == ADDR_SER2_PTR;
    assign hit_win[2] = mem_addr == ADDR_SER2_WIN;
    wire logic hit_prio = mem_addr == ADDR_DMA_PRIO;
    wire logic hit_dptr = mem_addr == ADDR_DMA_PTR;
    wire logic hit_wini = mem_addr == ADDR_DMA_WINI;
    wire logic hit_winn = mem_addr == ADDR_DMA_WINN;
    wire logic hit_dwin = hit_wini | hit_winn;
    wire logic hit_any  = (|hit_ptr) | (|hit_win) | hit_prio
        | hit_dptr | hit_dwin;

    // ------------------------------------------------------------
    // Range checks
    // ------------------------------------------------------------
    wire logic [2:0] ser_valid;
    for (genvar p = 0; p < 3; p++) begin : g_ser_valid
        assign ser_valid[p] = ser_ok(serial_subbank_pointer[p]);
    end
    wire logic dma_ok = dma_in_range(dma_subbank_pointer);

    // ------------------------------------------------------------
    // Write enables
    // ------------------------------------------------------------
    // Pointer and window writes are one-cycle strobes from the core
    wire logic [2:0] we_ptr  = {3{mem_wr}} & hit_ptr;
    wire logic [2:0] we_win  = {3{mem_wr}} & hit_win & ser_valid;
    wire logic       we_prio = mem_wr & hit_prio;
    wire logic       we_dptr = mem_wr & hit_dptr;
    wire logic       we_dwin = mem_wr & hit_dwin & dma_ok;
    // A pointer write wins over a step in the same cycle
    wire logic       step_dptr = acc & hit_wini & ~we_dptr;
    wire logic [15:0] next_dptr = we_dptr ? mem_wdata
        : dma_subbank_pointer + 16'h0001;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Serial control registers have no direct address at all
    wire logic [15:0] ser_rd [3];
    for (genvar p = 0; p < 3; p++) begin : g_ser_rd
        assign ser_rd[p] = pick(ser_valid[p],
            ser_ctl[p][ser_idx(serial_subbank_pointer[p])]);
    end
    wire logic [15:0] dma_rd = pick(dma_ok,
        dma_ctl[dma_idx(dma_subbank_pointer)]);

    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = 16'h0000;
        for (int p = 0; p < 3; p++) begin
            if (hit_ptr[p]) begin
                next_rdata = serial_subbank_pointer[p];
            end
            if (hit_win[p]) begin
                next_rdata = ser_rd[p];
            end
        end
        if (hit_prio) begin
            next_rdata = dma_priority_enable;
        end
        if (hit_dptr) begin
            next_rdata = dma_subbank_pointer;
        end
        if (hit_dwin) begin
            next_rdata = dma_rd;
        end
    end

    // ------------------------------------------------------------
    // Answer registers
    // ------------------------------------------------------------
    // Read data is cleared on idle cycles so a stale word never lingers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_rdata <= RST_VAL;
            mem_hit   <= 1'b0;
        end else begin
            mem_rdata <= mem_rd ? next_rdata : RST_VAL;
            mem_hit   <= acc & hit_any;
        end
    end

    // ------------------------------------------------------------
    // Serial subbanks
    // ------------------------------------------------------------
    for (genvar p = 0; p < 3; p++) begin : g_ser
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                serial_subbank_pointer[p] <= RST_VAL;
            end else if (we_ptr[p]) begin
                serial_subbank_pointer[p] <= mem_wdata;
            end
        end
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                for (int i = 0; i < SER_NREG; i++) begin
                    ser_ctl[p][i] <= RST_VAL;
                end
            end else if (we_win[p]) begin
                ser_ctl[p][ser_idx(serial_subbank_pointer[p])]
                    <= mem_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // DMA registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dma_priority_enable <= RST_VAL;
        end else if (we_prio) begin
            dma_priority_enable <= mem_wdata;
        end
    end

    // Steps even past the last register; software reloads the pointer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dma_subbank_pointer <= RST_VAL;
        end else if (we_dptr | step_dptr) begin
            dma_subbank_pointer <= next_dptr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < DMA_NREG; i++) begin
                dma_ctl[i] <= RST_VAL;
            end
        end else if (we_dwin) begin
            dma_ctl[dma_idx(dma_subbank_pointer)] <= mem_wdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Mapped set written out again so the checks skip the decode
    wire logic addr_mapped = mem_addr inside {
        ADDR_SER2_PTR, ADDR_SER2_WIN, ADDR_SER0_PTR, ADDR_SER0_WIN,
        ADDR_SER1_PTR, ADDR_SER1_WIN, ADDR_DMA_PRIO, ADDR_DMA_PTR,
        ADDR_DMA_WINI, ADDR_DMA_WINN};

    a_dma_autoinc: assert property (
        @(posedge clk_sys) disable iff (rst)
        acc && hit_wini |=>
        dma_subbank_pointer == $past(dma_subbank_pointer) + 16'h0001
    ) else $error("autoinc window did not step pointer");

    a_dma_plain: assert property (
        @(posedge clk_sys) disable iff (rst)
        acc && hit_winn |=>
        dma_subbank_pointer == $past(dma_subbank_pointer)
    ) else $error("plain window changed pointer");

    a_dptr_wr: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_wr && hit_dptr |=>
        dma_subbank_pointer == $past(mem_wdata)
    ) else $error("DMA pointer write lost");

    a_dptr_rd: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_rd && hit_dptr |=>
        mem_rdata == $past(dma_subbank_pointer)
    ) else $error("DMA pointer readback wrong");

    a_prio_rd: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_wr && hit_prio ##1 !mem_wr ##1 mem_rd && hit_prio && !mem_wr
        |=> mem_rdata == $past(mem_wdata, 3)
    ) else $error("priority register readback wrong");

    a_ser_ptr_wr: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_wr && hit_ptr[0] |=>
        serial_subbank_pointer[0] == $past(mem_wdata)
    ) else $error("serial pointer write lost");

    a_ser1_ptr_wr: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_wr && hit_ptr[1] |=>
        serial_subbank_pointer[1] == $past(mem_wdata)
    ) else $error("port 1 pointer write lost");

    a_ser2_ptr_wr: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_wr && hit_ptr[2] |=>
        serial_subbank_pointer[2] == $past(mem_wdata)
    ) else $error("port 2 pointer write lost");

    a_ser_ptr_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        !(mem_wr && mem_addr == ADDR_SER1_PTR) |=>
        $stable(serial_subbank_pointer[1])
    ) else $error("port 1 pointer changed without a write");

    a_ser_win_rd: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_rd && hit_win[1] |=>
        mem_rdata == $past(ser_rd[1])
    ) else $error("serial window read wrong");

    a_ser_wr_rd: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_wr && hit_win[0] && ser_valid[0] ##1 !mem_wr ##1
        mem_rd && !mem_wr && hit_win[0] && $stable(serial_subbank_pointer[0])
        |=> mem_rdata == $past(mem_wdata, 3)
    ) else $error("serial window write lost");

    a_ser_range: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_rd && hit_win[2] && serial_subbank_pointer[2] > SER_LAST_SUB
        |=> mem_rdata == 16'h0000
    ) else $error("empty serial slot not zero");

    a_dma_range: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_rd && hit_dwin && dma_subbank_pointer > DMA_LAST_SUB
        |=> mem_rdata == 16'h0000
    ) else $error("empty DMA slot not zero");

    a_unmapped_miss: assert property (
        @(posedge clk_sys) disable iff (rst)
        acc && !addr_mapped |=>
        !mem_hit && mem_rdata == 16'h0000
    ) else $error("unmapped address answered");

    a_mapped_hit: assert property (
        @(posedge clk_sys) disable iff (rst)
        acc && addr_mapped |=>
        mem_hit
    ) else $error("mapped address not answered");

    a_idle_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        !mem_rd |=>
        mem_rdata == 16'h0000
    ) else $error("read data not cleared when idle");

    a_rst_clear: assert property (
        @(posedge clk_sys)
        rst |=> mem_rdata == 16'h0000 && !mem_hit
        && dma_subbank_pointer == 16'h0000 && dma_priority_enable == 16'h0000
    ) else $error("reset left state behind");

    c_autoinc: cover property (@(posedge clk_sys)
        acc && hit_wini ##1 acc && hit_wini);
    c_ser_rd: cover property (@(posedge clk_sys)
        mem_rd && hit_win[0]);
    c_dma_oob: cover property (@(posedge clk_sys)
        mem_rd && hit_dwin && !dma_ok);
    c_ser_oob: cover property (@(posedge clk_sys)
        mem_rd && hit_win[2] && !ser_valid[2]);
    c_prio_wr_rd: cover property (@(posedge clk_sys)
        mem_wr && hit_prio ##2 mem_rd && hit_prio);
endmodule // sbra_bank
`default_nettype wire

// File: sbra_core.sv
// Core model issuing single-cycle data-memory accesses
`timescale 1ns/1ns
`default_nettype none
module sbra_core
    import sbra_pkg::*;
(
    // Clock
    input  wire logic               clk_sys,
    // Access towards the block
    output var  logic               mem_rd,
    output var  logic               mem_wr,
    output var  logic [SBRA_AW-1:0] mem_addr,
    output var  logic [SBRA_DW-1:0] mem_wdata,
    input  wire logic [SBRA_DW-1:0] mem_rdata
);
    initial begin
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_addr = 7'h00;
        mem_wdata = 16'h0000;
    end
    // Released address and data lines show inverted values so stale data cannot pass
    task automatic acc(input logic w, input logic [6:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_sys);
        mem_wr <= w;
        mem_rd <= ~w;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge clk_sys);
        mem_wr <= 1'b0;
        mem_rd <= 1'b0;
        mem_addr <= ~a;
        mem_wdata <= ~d;
        #1 q = mem_rdata;
    endtask
endmodule // sbra_core
`default_nettype wire

// File: sbra_bank_test.sv
// Self-checking bench for the subbank register access block
`timescale 1ns/1ns
`default_nettype none
module sbra_bank_test;
    import sbra_pkg::*;
    logic clk_sys, rst, mem_rd, mem_wr, mem_hit;
    logic [6:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata, q;
    int failures, n_compared, cycles;
    sbra_core core(.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    sbra_bank dut(.clk_sys(clk_sys), .rst(rst), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_hit(mem_hit));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] r;
        core.acc(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        core.acc(1'b0, a, 16'h0000, q);
        chk(q, exp);
    endtask
    task automatic t_direct;
        rd(ADDR_DMA_PTR, RST_VAL);
        wr(ADDR_DMA_PRIO, 16'hBEEF);
        rd(ADDR_DMA_PRIO, 16'hBEEF);
        rd(7'h36, 16'h0000);
        chk({15'h0000, mem_hit}, 16'h0000);
        $display("direct registers done");
    endtask
    task automatic t_serial;
        logic [6:0] p[3] = '{ADDR_SER0_PTR, ADDR_SER1_PTR, ADDR_SER2_PTR};
        for (int i = 0; i < 3; i++)
            for (int s = 0; s < SER_NREG; s++) begin
                wr(p[i], 16'(s));
                wr(p[i] + 7'h01, 16'hA000 | 16'(i << 8) | 16'(s));
            end
        for (int i = 0; i < 3; i++) begin
            for (int s = 0; s < SER_NREG; s++) begin
                wr(p[i], 16'(s));
                rd(p[i] + 7'h01, 16'hA000 | 16'(i << 8) | 16'(s));
                chk({15'h0000, mem_hit}, 16'h0001);
            end
            wr(p[i], 16'h000F);
            wr(p[i] + 7'h01, 16'hFFFF);
            rd(p[i] + 7'h01, 16'h0000);
            wr(p[i], SER_LAST_SUB);
            rd(p[i] + 7'h01, 16'hA00E | 16'(i << 8));
            wr(p[i] + 7'h01, 16'h5A00 | 16'(i));
            rd(p[i] + 7'h01, 16'h5A00 | 16'(i));
        end
        $display("serial subbank done");
    endtask
    task automatic t_dma;
        wr(ADDR_DMA_PTR, 16'h0000);
        for (int s = 0; s < DMA_NREG; s++)
            wr(ADDR_DMA_WINI, 16'hD000 | 16'(s));
        rd(ADDR_DMA_PTR, 16'h0028);
        wr(ADDR_DMA_PTR, 16'h0000);
        for (int s = 0; s < DMA_NREG; s++)
            rd(ADDR_DMA_WINI, 16'hD000 | 16'(s));
        wr(ADDR_DMA_PTR, 16'h0005);
        rd(ADDR_DMA_WINN, 16'hD005);
        rd(ADDR_DMA_WINN, 16'hD005);
        rd(ADDR_DMA_PTR, 16'h0005);
        wr(ADDR_DMA_PTR, 16'h0028);
        wr(ADDR_DMA_WINN, 16'h1234);
        rd(ADDR_DMA_WINN, 16'h0000);
        wr(ADDR_DMA_PTR, DMA_LAST_SUB);
        rd(ADDR_DMA_WINN, 16'hD027);
        $display("dma subbank done");
    endtask
    task automatic t_reset;
        wr(ADDR_DMA_PRIO, 16'h00A5);
        wr(ADDR_SER1_PTR, 16'h0003);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ADDR_DMA_PRIO, RST_VAL);
        rd(ADDR_SER1_PTR, RST_VAL);
        rd(ADDR_DMA_PTR, RST_VAL);
        $display("mid-run reset done");
    endtask
    task automatic test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Ceiling well above the roughly 600 cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_direct();
        t_serial();
        t_dma();
        t_reset();
        test_done();
    end
endmodule // sbra_bank_test
`default_nettype wire
